// ### core/vsw_i2c_slave.sv
`timescale 1ns/1ns
`default_nettype none
module vsw_i2c_slave (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic ADDR_SELECT_HI_PIN,
   input wire logic ADDR_SELECT_LO_PIN,
   input wire logic [3:0] SOURCE_POWER,
   output logic [7:0] SINK_ONE_CONFIG,
   output logic [7:0] SINK_TWO_CONFIG,
   output logic [7:0] PLUG_CONTROL
);
   import vsw_pkg::*;

   logic [PIN_W-1:0] pins;
   logic scl_q;
   logic sda_q;
   vsw_state_t state;
   vsw_state_t next_state;
   logic [3:0] bitcnt;
   logic [3:0] next_bitcnt;
   logic [7:0] shreg;
   logic [7:0] next_shreg;
   logic [1:0] ptr;
   logic [1:0] next_ptr;
   logic rw;
   logic next_rw;
   logic sda_oe;
   logic next_oe;
   logic sda_out;
   logic wr_en;
   logic [7:0] sink_one;
   logic [7:0] sink_two;
   logic [7:0] plug_ctrl;

   vsw_pin_filter #(
      .WIDTH(PIN_W),
      .RESET_VAL(PIN_RESET)
   ) u_filter (
      .CLK(CLK),
      .RST_B(RST_B),
      .pin_in({SCL_IN, SDA_IN, ADDR_SELECT_HI_PIN, ADDR_SELECT_LO_PIN, SOURCE_POWER}),
      .pin_out(pins)
   );

   wire scl = pins[PIN_SCL];
   wire sda = pins[PIN_SDA];
   wire [3:0] power = pins[3:0];

   // bus events from filtered levels
   wire scl_rise = scl && !scl_q;
   wire scl_fall = !scl && scl_q;
   wire start_cond = scl && scl_q && sda_q && !sda;
   wire stop_cond = scl && scl_q && !sda_q && sda;
   wire byte_done = (bitcnt == BYTE_BITS);

   // pin bits compared live, never latched
   wire [6:0] own_addr = {SLAVE_ADDR_FIXED, pins[PIN_A_HI], pins[PIN_A_LO]};
   wire addr_match = (shreg[7:1] == own_addr);

   function automatic logic [7:0] read_mux(input logic [1:0] sel, input logic [7:0] one,
                                           input logic [7:0] two, input logic [7:0] ctrl,
                                           input logic [3:0] pwr);
      logic [7:0] r;
      r = READ_NONE;
      if (sel == PTR_SINK_ONE) begin
         r = one;
      end else if (sel == PTR_SINK_TWO) begin
         r = two;
      end else if (sel == PTR_PLUG_STATUS) begin
         r = ctrl | {PWR_PAD, pwr};
      end
      return r;
   endfunction

   wire [7:0] read_value = read_mux(ptr, sink_one, sink_two, plug_ctrl, power);
   wire wr_sink_one = wr_en && (ptr == PTR_SINK_ONE);
   wire wr_sink_two = wr_en && (ptr == PTR_SINK_TWO);
   wire wr_plug = wr_en && (ptr == PTR_PLUG_STATUS);

   // protocol sequencer, next values
   always_comb begin
      next_state = state;
      next_bitcnt = bitcnt;
      next_shreg = shreg;
      next_ptr = ptr;
      next_rw = rw;
      next_oe = sda_oe;
      wr_en = 1'b0;
      if (stop_cond) begin
         next_state = ST_IDLE;
         next_oe = 1'b0;
      end else if (start_cond) begin
         next_state = ST_ADDR;
         next_bitcnt = BIT_ZERO;
         next_oe = 1'b0;
      end else begin
         unique case (state)
            ST_IDLE, ST_WAIT: begin
               next_oe = 1'b0;
            end
            ST_ADDR, ST_SUB, ST_WDATA: begin
               if (scl_rise && !byte_done) begin
                  // sample on rising clock, msb first
                  next_shreg = {shreg[6:0], sda};
                  next_bitcnt = bitcnt + BIT_STEP;
               end else if (scl_fall && byte_done) begin
                  next_bitcnt = BIT_ZERO;
                  if (state == ST_ADDR) begin
                     next_rw = shreg[0];
                     next_oe = addr_match;
                     next_state = addr_match ? ST_ADDR_ACK : ST_WAIT;
                  end else if (state == ST_SUB) begin
                     next_ptr = shreg[1:0];
                     next_oe = 1'b1;
                     next_state = ST_SUB_ACK;
                  end else begin
                     wr_en = 1'b1;
                     next_oe = 1'b1;
                     next_state = ST_WDATA_ACK;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (rw == RW_READ) begin
                     next_shreg = read_value;
                     next_oe = !read_value[7];
                     next_state = ST_RDATA;
                  end else begin
                     next_oe = 1'b0;
                     next_state = ST_SUB;
                  end
               end
            end
            ST_SUB_ACK: begin
               if (scl_fall) begin
                  next_oe = 1'b0;
                  next_state = ST_WDATA;
               end
            end
            ST_WDATA_ACK: begin
               if (scl_fall) begin
                  next_oe = 1'b0;
                  next_state = ST_WAIT;
               end
            end
            ST_RDATA: begin
               if (scl_rise) begin
                  next_bitcnt = bitcnt + BIT_STEP;
               end else if (scl_fall) begin
                  if (byte_done) begin
                     next_oe = 1'b0;
                     next_state = ST_RDATA_ACK;
                  end else begin
                     // shift next bit out on falling clock
                     next_shreg = {shreg[6:0], 1'b0};
                     next_oe = !shreg[6];
                  end
               end
            end
            ST_RDATA_ACK: begin
               if (scl_fall) begin
                  next_state = ST_WAIT;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         sda_out <= SDA_DRIVE_LEVEL;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         sda_out <= SDA_DRIVE_LEVEL;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state <= ST_IDLE;
         bitcnt <= BIT_ZERO;
         shreg <= READ_NONE;
         ptr <= PTR_RESET;
         rw <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         state <= next_state;
         bitcnt <= next_bitcnt;
         shreg <= next_shreg;
         ptr <= next_ptr;
         rw <= next_rw;
         sda_oe <= next_oe;
      end
   end

   // register writes, reserved bits kept zero
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         sink_one <= SINK_ONE_RESET;
         sink_two <= SINK_TWO_RESET;
         plug_ctrl <= PLUG_STATUS_RESET & PLUG_CTRL_MASK;
      end else begin
         if (wr_sink_one) begin
            sink_one <= shreg & CONFIG_MASK;
         end
         if (wr_sink_two) begin
            sink_two <= shreg & CONFIG_MASK;
         end
         if (wr_plug) begin
            plug_ctrl <= shreg & PLUG_CTRL_MASK; // power bits read-only
         end
      end
   end

   // open drain: only ever pulls low
   assign SDA_OUT = sda_out;
   assign SDA_OE = sda_oe;
   assign SINK_ONE_CONFIG = sink_one;
   assign SINK_TWO_CONFIG = sink_two;
   assign PLUG_CONTROL = plug_ctrl;
endmodule
`default_nettype wire

// ### core/vsw_pkg.sv
`default_nettype none
package vsw_pkg;
   // system clock and serial bus rates
   localparam int CLK_PERIOD_NS = 8;
   localparam int STD_RATE_KBPS = 100;
   localparam int FAST_RATE_KBPS = 400;
   // shortest fast-mode clock phase, far longer than the filter delay
   localparam int FAST_HIGH_NS = 600;
   localparam int FAST_HIGH_CYCLES = FAST_HIGH_NS / CLK_PERIOD_NS;
   // spikes shorter than this are ignored on every pin
   localparam int GLITCH_NS = 50;
   localparam int GLITCH_CYCLES = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_CNT_W = 4;
   localparam logic [FILT_CNT_W-1:0] FILT_LIMIT = FILT_CNT_W'(GLITCH_CYCLES);
   localparam logic [FILT_CNT_W-1:0] FILT_ZERO = 4'h0;
   localparam logic [FILT_CNT_W-1:0] FILT_STEP = 4'h1;

   // slave address: five fixed bits, two from pins
   localparam logic [4:0] SLAVE_ADDR_FIXED = 5'h0b;
   localparam logic RW_READ = 1'b1;

   // sub-address pointer
   localparam logic [5:0] PTR_UPPER_ZERO = 6'h00;
   localparam logic [1:0] PTR_SINK_ONE = 2'h1;
   localparam logic [1:0] PTR_SINK_TWO = 2'h2;
   localparam logic [1:0] PTR_PLUG_STATUS = 2'h3;
   localparam logic [1:0] PTR_RESET = 2'h3;

   // register reset values and writable fields
   localparam logic [7:0] SINK_ONE_RESET = 8'h08;
   localparam logic [7:0] SINK_TWO_RESET = 8'h09;
   localparam logic [7:0] PLUG_STATUS_RESET = 8'h10;
   localparam logic [7:0] CONFIG_MASK = 8'h1f;
   localparam logic [7:0] PLUG_CTRL_MASK = 8'h30;
   localparam logic [7:0] READ_NONE = 8'h00;
   localparam logic [3:0] PWR_PAD = 4'h0;

   // byte framing
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] BIT_ZERO = 4'h0;
   localparam logic [3:0] BIT_STEP = 4'h1;
   localparam logic SDA_DRIVE_LEVEL = 1'b0;

   // filtered input vector layout
   localparam int PIN_W = 8;
   localparam int PIN_SCL = 7;
   localparam int PIN_SDA = 6;
   localparam int PIN_A_HI = 5;
   localparam int PIN_A_LO = 4;
   localparam logic [PIN_W-1:0] PIN_RESET = 8'hc0;

   typedef enum logic [9:0] {
      ST_IDLE      = 10'h001,
      ST_ADDR      = 10'h002,
      ST_ADDR_ACK  = 10'h004,
      ST_SUB       = 10'h008,
      ST_SUB_ACK   = 10'h010,
      ST_WDATA     = 10'h020,
      ST_WDATA_ACK = 10'h040,
      ST_RDATA     = 10'h080,
      ST_RDATA_ACK = 10'h100,
      ST_WAIT      = 10'h200
   } vsw_state_t;
endpackage
`default_nettype wire

// ### core/vsw_pin_filter.sv
`timescale 1ns/1ns
`default_nettype none
module vsw_pin_filter #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out
);
   import vsw_pkg::*;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta;
         logic sync;
         logic [FILT_CNT_W-1:0] cnt;
         logic filt;
         wire differs = (sync != filt);
         wire settled = (cnt == FILT_LIMIT);
         // two-stage synchroniser, first stage read only by the second
         always_ff @(posedge CLK or negedge RST_B) begin
            if (!RST_B) begin
               meta <= RESET_VAL[i];
               sync <= RESET_VAL[i];
            end else begin
               meta <= pin_in[i];
               sync <= meta;
            end
         end
         // a level must hold for the whole window before it is taken
         always_ff @(posedge CLK or negedge RST_B) begin
            if (!RST_B) begin
               cnt <= FILT_ZERO;
               filt <= RESET_VAL[i];
            end else if (!differs) begin
               cnt <= FILT_ZERO;
            end else if (settled) begin
               cnt <= FILT_ZERO;
               filt <= sync;
            end else begin
               cnt <= cnt + FILT_STEP;
            end
         end
         assign pin_out[i] = filt;
      end
   endgenerate
endmodule
`default_nettype wire

// ### tb/vsw_i2c_slave_checker.sv
`timescale 1ns/1ns
`default_nettype none
module vsw_i2c_slave_checker
   import vsw_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   input wire logic ADDR_SELECT_HI_PIN,
   input wire logic ADDR_SELECT_LO_PIN,
   input wire logic [3:0] SOURCE_POWER,
   input wire logic [7:0] SINK_ONE_CONFIG,
   input wire logic [7:0] SINK_TWO_CONFIG,
   input wire logic [7:0] PLUG_CONTROL
);
   logic [4:0] scl_hi;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // cycles the clock pin has stayed high, saturating
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         scl_hi <= 5'h00;
      end else begin
         scl_hi <= !SCL_IN ? 5'h00 : (scl_hi == 5'h1f ? scl_hi : scl_hi + 5'h01);
      end
   end
   a_pull_low_only: assert property (SDA_OUT == SDA_DRIVE_LEVEL)
      else $error("data output not low");
   a_cfg_reserved_zero: assert property (SINK_ONE_CONFIG[7:5] == 3'h0 && SINK_TWO_CONFIG[7:5] == 3'h0)
      else $error("config reserved bits set");
   a_plug_bits_only: assert property ((PLUG_CONTROL & ~PLUG_CTRL_MASK) == 8'h00)
      else $error("plug control stray bits");
   // registers change only after a clock fall
   a_regs_hold_high: assert property (scl_hi > 5'd20 |-> $stable({SINK_ONE_CONFIG, SINK_TWO_CONFIG, PLUG_CONTROL}))
      else $error("register changed in clock high");
   a_oe_moves_low: assert property ($changed(SDA_OE) |-> !SCL_IN)
      else $error("drive changed with clock high");
   a_oe_stands_high: assert property (SDA_OE && $rose(SCL_IN) |=> SDA_OE [*8])
      else $error("drive dropped in high phase");
   a_stop_frees_line: assert property (SCL_IN && $rose(SDA_IN) |=> !SDA_OE [*8])
      else $error("drive after stop");
   a_start_no_drive: assert property (SCL_IN && $fell(SDA_IN) |=> !SDA_OE [*8])
      else $error("drive after start");
   // main scenarios reached
   c_ack: cover property ($rose(SDA_OE));
   c_sink_two: cover property ($changed(SINK_TWO_CONFIG));
   c_plug: cover property ($changed(PLUG_CONTROL));
endmodule
bind vsw_i2c_slave vsw_i2c_slave_checker u_chk (.CLK(CLK), .RST_B(RST_B), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
   .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ADDR_SELECT_HI_PIN(ADDR_SELECT_HI_PIN),
   .ADDR_SELECT_LO_PIN(ADDR_SELECT_LO_PIN), .SOURCE_POWER(SOURCE_POWER), .SINK_ONE_CONFIG(SINK_ONE_CONFIG),
   .SINK_TWO_CONFIG(SINK_TWO_CONFIG), .PLUG_CONTROL(PLUG_CONTROL));
`default_nettype wire

// ### tb/vsw_master.sv
`timescale 1ns/1ns
`default_nettype none
module vsw_master (
   input wire logic CLK,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   // phases kept well above the pin filter delay
   localparam int PH = 50;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge CLK);
   endtask
   task automatic start();
      wt(25);
      sda_low <= 1'b1;
      wt(PH);
      scl <= 1'b0;
   endtask
   // data set only while clock low
   task automatic bitx(input logic b, output logic r);
      wt(PH / 4);
      sda_low <= !b;
      wt(PH);
      scl <= 1'b1;
      wt(PH / 2);
      r = sda;
      wt(PH / 2);
      scl <= 1'b0;
   endtask
   // msb first, released in ack slot
   task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], q[i]);
      end
      bitx(1'b1, ack);
   endtask
   task automatic stop();
      wt(PH / 4);
      sda_low <= 1'b1;
      wt(PH);
      scl <= 1'b1;
      wt(PH);
      sda_low <= 1'b0;
      wt(1);
   endtask
endmodule
`default_nettype wire

// ### tb/vsw_i2c_slave_test.sv
`timescale 1ns/1ns
`default_nettype none
module vsw_i2c_slave_test;
   import vsw_pkg::*;
   logic CLK = 1'b0;
   logic RST_B = 1'b0;
   logic a_hi = 1'b0;
   logic a_lo = 1'b0;
   logic seen_v = 1'b0;
   logic [3:0] pwr = 4'h0;
   logic scl, m_low, oe, s_out, sda, k;
   logic [7:0] c1, c2, pc, q, v, e, seen;
   logic [2:0] ak;
   logic [31:0] rs = 32'h84a3f10e;
   logic [7:0] exp_q [$];
   string what;
   int failures = 0;
   int checked = 0;
   // open-drain line with pull-up
   assign sda = !((oe & !s_out) | m_low);
   always #4 CLK = !CLK;
   vsw_master u_m (.CLK(CLK), .sda(sda), .scl(scl), .sda_low(m_low));
   vsw_i2c_slave dut_u (.CLK(CLK), .RST_B(RST_B), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(s_out), .SDA_OE(oe),
      .ADDR_SELECT_HI_PIN(a_hi), .ADDR_SELECT_LO_PIN(a_lo), .SOURCE_POWER(pwr), .SINK_ONE_CONFIG(c1),
      .SINK_TWO_CONFIG(c2), .PLUG_CONTROL(pc));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction
   function automatic logic [7:0] adr(input logic rw);
      return {SLAVE_ADDR_FIXED, a_hi, a_lo, rw};
   endfunction
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
      checked++;
      if (s !== x) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic note(input string n, input logic [7:0] x, input logic [7:0] s);
      exp_q.push_back(x);
      what <= n;
      seen <= s;
      seen_v <= 1'b1;
      @(posedge CLK);
      seen_v <= 1'b0;
      @(posedge CLK);
   endtask
   task automatic wr(input logic [7:0] sub, input logic [7:0] d, input logic more);
      u_m.start();
      u_m.xfer(adr(1'b0), q, ak[2]);
      u_m.xfer(sub, q, ak[1]);
      u_m.xfer(d, q, ak[0]);
      if (more) begin
         u_m.xfer(~d, q, k);
      end
      u_m.stop();
   endtask
   task automatic rd(output logic [7:0] r);
      u_m.start();
      u_m.xfer(adr(RW_READ), q, ak[2]);
      u_m.xfer(8'hff, r, k);
      u_m.stop();
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // oldest note against each seen result
   always @(posedge CLK) begin
      if (seen_v === 1'b1) begin
         chk(what, seen, exp_q.pop_front());
      end
   end
   // hang guard, a full run is about 45k cycles
   initial begin
      repeat (95000) @(posedge CLK);
      failures++;
      finish_test();
   end
   initial begin
      repeat (3) @(posedge CLK);
      RST_B <= 1'b1;
      note("sink1", SINK_ONE_RESET, c1);
      note("sink2", SINK_TWO_RESET, c2);
      note("plug", PLUG_STATUS_RESET, pc);
      rs = xs(rs);
      pwr <= rs[3:0];
      rd(v);
      note("rd0", PLUG_STATUS_RESET | {4'h0, pwr}, v);
      $display("test reset done");
      // write then read back each register
      for (int i = 1; i < 4; i++) begin
         rs = xs(rs);
         wr(8'(i), rs[7:0], 1'b0);
         note("wack", 8'h00, {5'h0, ak});
         e = rs[7:0] & ((i == 3) ? PLUG_CTRL_MASK : CONFIG_MASK);
         rd(v);
         note("rback", (i == 3) ? (e | {4'h0, pwr}) : e, v);
         note("out", e, (i == 1) ? c1 : ((i == 2) ? c2 : pc));
      end
      $display("test registers done");
      // every pin setting: own address acked, one address differing in a single bit refused
      for (int p = 0; p < 4; p++) begin
         a_hi <= p[1];
         a_lo <= p[0];
         rd(v);
         note("own", 8'h00, {7'h0, ak[2]});
         u_m.start();
         u_m.xfer(adr(RW_READ) ^ (p[0] ? 8'h02 : 8'h40), q, k);
         u_m.stop();
         note("other", 8'h01, {7'h0, k});
      end
      $display("test address done");
      // second data byte refused and dropped
      wr(8'h01, 8'h15, 1'b1);
      note("extra", 8'h01, {7'h0, k});
      note("kept", 8'h15, c1);
      // only the low two pointer bits count
      wr(8'h05, 8'h0c, 1'b0);
      note("wrap", 8'h0c, c1);
      wr(8'h04, 8'h1f, 1'b0);
      rd(v);
      note("ptr0", READ_NONE, v);
      note("ptr0w", 8'h0c, c1);
      $display("test pointer done");
      finish_test();
   end
endmodule
`default_nettype wire
